// file: rae_pkg.sv
// Behaviour
// - Any reset wins over address errors and all other exception sources
// - Pin power-on reset initialises core, peripherals, pin function and port state
// - Manual reset with power-on pin high initialises only the core state
// - Enabled watchdog overflow enters the power-on reset state
// - Watchdog power-on reset leaves pin function and port registers alone
// - Pin and watchdog reset together: pin wins, overflow flag cleared
// - On release fetch PC then SP, clear vector base, mask to 1111, run
// - Manual reset release runs the same fetch and initialise sequence
// - Manual reset waits for the current bus cycle to finish
// - Instruction fetch from an odd address is an address error
// - Instruction fetch from peripheral space is an address error
// - Single-chip mode: any external space access is an address error
// - Odd word access or unaligned longword access is an address error
// - Longword access to an 8-bit peripheral is an address error
// - Error handling starts after bus cycle and instruction end
// - Push status word then next PC, load handler, no delay slot
// - Reset vectors at 0 and 4 (power-on), 8 and c (manual)
// - Error vector is base plus four times 9 (core, trace) or 10
// - Error push goes through the stack register, mask bits unchanged
package rae_pkg;
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_VBASE = 4'h4;
	localparam logic [3:0] OFF_ERRADDR = 4'h8;
	localparam int CTRL_WATCHDOG_OVERFLOW_FLAG = 0;
	localparam int CTRL_WDT_EN = 1;
	localparam int CTRL_SCHIP = 2;
	localparam int CTRL_CAUSE = 4;
	localparam int SR_IMASK = 4;
	localparam logic [31:0] VEC_POR_PC = 32'h0000_0000;
	localparam logic [31:0] VEC_MAN_PC = 32'h0000_0008;
	localparam logic [31:0] VEC_STEP = 32'h0000_0004;
	localparam logic [7:0] VEC_AE_CORE = 8'h09;
	localparam logic [7:0] VEC_AE_DMA = 8'h0a;
	localparam logic [31:0] VBASE_RST = 32'h0000_0000;
	localparam logic [3:0] IMASK_RST = 4'hf;
	localparam logic [31:0] PERIPH_LO = 32'hffff_8000;
	localparam logic [31:0] PERIPH_HI = 32'hffff_bfff;
	localparam logic [31:0] PERIPH8_LO = 32'hffff_8000;
	localparam logic [31:0] PERIPH8_HI = 32'hffff_83ff;
	localparam logic [31:0] EXT_LO = 32'h0040_0000;
	localparam logic [31:0] EXT_HI = 32'hfffe_ffff;
	localparam int CLK_NS = 5;
	localparam int WDT_RST_NS = 80;
	localparam logic [7:0] WDT_RST_CYC = 8'((WDT_RST_NS + CLK_NS - 1) / CLK_NS);
	typedef enum logic [1:0] {M_CPU, M_DMA, M_TRACE, M_XFER} master_t;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_t;
	typedef enum logic [1:0] {C_NONE, C_PIN, C_WDT, C_MAN} cause_t;
	typedef struct packed {
		logic valid;
		logic fetch;
		master_t master;
		size_t size;
		logic [31:0] addr;
	} access_t;
	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_cmd_t;
endpackage

// file: rae_unit.sv
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module rae_unit import rae_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic power_on_reset_pin_n,
	input wire logic manual_reset_pin_n,
	input wire logic watchdog_overflow,
	input wire logic bus_cycle_busy,
	input wire logic instr_done,
	input wire access_t acc,
	input wire logic [31:0] cur_status_word,
	input wire logic [31:0] cur_stack_ptr,
	input wire logic [31:0] next_pc,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic cpu_init,
	output logic periph_init,
	output logic port_init,
	output logic core_hold,
	output mem_cmd_t mem_cmd,
	output logic [31:0] pc_out,
	output logic [31:0] sp_out,
	output logic [31:0] status_word_out,
	output logic pc_load,
	output logic sp_load,
	output logic sr_load,
	output logic addr_error
);
	typedef enum logic [2:0] {RUN, RST_HOLD, FETCH_PC, FETCH_SP, PUSH_SR, PUSH_PC,
		FETCH_HANDLER} state_t;
	state_t state_ff;
	cause_t cause_ff;
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic wait_ff, watchdog_overflow_flag_ff, wdt_en_ff, schip_ff, ae_pend_ff, addr_error_ff;
	logic cpu_init_ff, periph_init_ff, port_init_ff, core_hold_ff;
	logic pc_load_ff, sp_load_ff, sr_load_ff;
	logic [7:0] hold_cnt_ff, vec_ff;
	logic [31:0] vbase_ff, err_addr_ff, pc_ff, sp_ff, sr_ff, save_pc_ff, rdata_ff;
	mem_cmd_t mem_ff;

	// Reset release through two flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) rst_sync_ff <= 2'b00;
		else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_n = rst_sync_ff[1];

	// Reset requests
	wire por_pin = !power_on_reset_pin_n;
	wire wdt_rst = watchdog_overflow && wdt_en_ff;
	wire man_req = !manual_reset_pin_n;
	wire man_stall = (bus_cycle_busy && state_ff == RUN) || (mem_ff.req && !mem_ack);
	wire hold_exit = (cause_ff != C_WDT) || hold_cnt_ff == 8'h00;

	// Address error classification
	wire in_periph = acc.addr >= PERIPH_LO && acc.addr <= PERIPH_HI;
	wire in_p8 = acc.addr >= PERIPH8_LO && acc.addr <= PERIPH8_HI;
	wire in_ext = acc.addr >= EXT_LO && acc.addr <= EXT_HI;
	wire ext_err = schip_ff && in_ext;
	wire fetch_err = acc.addr[0] || in_periph;
	wire word_err = acc.size == SZ_WORD && acc.addr[0];
	wire long_err = acc.size == SZ_LONG && (acc.addr[1:0] != 2'b00 || in_p8);
	wire ae_hit = acc.valid && (ext_err || (acc.fetch ? fetch_err : (word_err || long_err)));
	wire dma_side = acc.master == M_DMA || acc.master == M_XFER;
	wire [7:0] ae_vec = dma_side ? VEC_AE_DMA : VEC_AE_CORE;
	wire ae_take = ae_pend_ff && instr_done && !bus_cycle_busy && state_ff == RUN;

	// Register bus decode
	wire bus_go = (avs_read || avs_write) && !wait_ff;
	wire wr_ctrl = bus_go && avs_write && avs_address == OFF_CTRL;
	wire wr_vbase = bus_go && avs_write && avs_address == OFF_VBASE;
	wire [31:0] ctrl_word = {26'h0, cause_ff, 1'b0, schip_ff, wdt_en_ff, watchdog_overflow_flag_ff};
	wire [31:0] rd_mux = avs_address == OFF_CTRL ? ctrl_word :
		avs_address == OFF_VBASE ? vbase_ff :
		avs_address == OFF_ERRADDR ? err_addr_ff : 32'h0000_0000;
	wire [31:0] handler_addr = vbase_ff + {22'h0, vec_ff, 2'b00};

	// Avalon slave: one wait cycle then answer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0000_0000;
		end else begin
			wait_ff <= !((avs_read || avs_write) && wait_ff);
			rdata_ff <= rd_mux;
		end
	end

	// Watchdog flag: enabled overflow sets, write one clears, pin reset clears
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) watchdog_overflow_flag_ff <= 1'b0;
		else if (por_pin) watchdog_overflow_flag_ff <= 1'b0;
		else if (wdt_rst) watchdog_overflow_flag_ff <= 1'b1;
		else if (wr_ctrl && avs_writedata[CTRL_WATCHDOG_OVERFLOW_FLAG]) watchdog_overflow_flag_ff <= 1'b0;
	end

	// Software control bits, peripheral state cleared by pin power-on reset only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wdt_en_ff <= 1'b0;
			schip_ff <= 1'b0;
		end else if (por_pin) begin
			wdt_en_ff <= 1'b0;
			schip_ff <= 1'b0;
		end else if (wr_ctrl) begin
			wdt_en_ff <= avs_writedata[CTRL_WDT_EN];
			schip_ff <= avs_writedata[CTRL_SCHIP];
		end
	end

	// Address error capture, new error beats the take
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ae_pend_ff <= 1'b0;
			addr_error_ff <= 1'b0;
			err_addr_ff <= 32'h0000_0000;
			vec_ff <= VEC_AE_CORE;
		end else begin
			addr_error_ff <= ae_hit;
			if (por_pin || wdt_rst || (man_req && !man_stall)) begin
				ae_pend_ff <= 1'b0;
			end else begin
				ae_pend_ff <= ae_hit || (ae_pend_ff && !ae_take);
			end
			if (ae_hit && (!ae_pend_ff || ae_take)) begin
				err_addr_ff <= acc.addr;
				vec_ff <= ae_vec;
			end
		end
	end

	// Exception sequencer, resets checked first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= RST_HOLD;
			cause_ff <= C_PIN;
			hold_cnt_ff <= 8'h00;
			cpu_init_ff <= 1'b1;
			periph_init_ff <= 1'b1;
			port_init_ff <= 1'b1;
			core_hold_ff <= 1'b1;
			vbase_ff <= VBASE_RST;
			pc_ff <= 32'h0000_0000;
			sp_ff <= 32'h0000_0000;
			sr_ff <= 32'h0000_0000;
			save_pc_ff <= 32'h0000_0000;
			mem_ff <= '0;
			pc_load_ff <= 1'b0;
			sp_load_ff <= 1'b0;
			sr_load_ff <= 1'b0;
		end else begin
			pc_load_ff <= 1'b0;
			sp_load_ff <= 1'b0;
			sr_load_ff <= 1'b0;
			if (por_pin) begin
				state_ff <= RST_HOLD;
				cause_ff <= C_PIN;
				cpu_init_ff <= 1'b1;
				periph_init_ff <= 1'b1;
				port_init_ff <= 1'b1;
				core_hold_ff <= 1'b1;
				mem_ff <= '0;
			end else if (wdt_rst) begin
				state_ff <= RST_HOLD;
				cause_ff <= C_WDT;
				hold_cnt_ff <= WDT_RST_CYC;
				cpu_init_ff <= 1'b1;
				periph_init_ff <= 1'b1;
				port_init_ff <= 1'b0;
				core_hold_ff <= 1'b1;
				mem_ff <= '0;
			end else if (man_req && !man_stall) begin
				state_ff <= RST_HOLD;
				cause_ff <= C_MAN;
				cpu_init_ff <= 1'b1;
				periph_init_ff <= 1'b0;
				port_init_ff <= 1'b0;
				core_hold_ff <= 1'b1;
				mem_ff <= '0;
			end else begin
				case (state_ff)
				RST_HOLD: begin
					if (hold_cnt_ff != 8'h00) hold_cnt_ff <= hold_cnt_ff - 8'h01;
					if (hold_exit) begin
						cpu_init_ff <= 1'b0;
						periph_init_ff <= 1'b0;
						port_init_ff <= 1'b0;
						vbase_ff <= VBASE_RST;
						sr_ff <= {24'h0, IMASK_RST, 4'h0};
						mem_ff.req <= 1'b1;
						mem_ff.we <= 1'b0;
						mem_ff.addr <= cause_ff == C_MAN ? VEC_MAN_PC : VEC_POR_PC;
						state_ff <= FETCH_PC;
					end
				end
				FETCH_PC: begin
					if (mem_ack) begin
						pc_ff <= mem_rdata;
						mem_ff.addr <= mem_ff.addr + VEC_STEP;
						state_ff <= FETCH_SP;
					end
				end
				FETCH_SP: begin
					if (mem_ack) begin
						sp_ff <= mem_rdata;
						mem_ff.req <= 1'b0;
						pc_load_ff <= 1'b1;
						sp_load_ff <= 1'b1;
						sr_load_ff <= 1'b1;
						core_hold_ff <= 1'b0;
						state_ff <= RUN;
					end
				end
				RUN: begin
					if (wr_vbase) vbase_ff <= avs_writedata;
					if (ae_take) begin
						core_hold_ff <= 1'b1;
						sp_ff <= cur_stack_ptr - VEC_STEP;
						save_pc_ff <= next_pc;
						mem_ff.req <= 1'b1;
						mem_ff.we <= 1'b1;
						mem_ff.addr <= cur_stack_ptr - VEC_STEP;
						mem_ff.wdata <= cur_status_word;
						state_ff <= PUSH_SR;
					end
				end
				PUSH_SR: begin
					if (mem_ack) begin
						sp_ff <= sp_ff - VEC_STEP;
						mem_ff.addr <= sp_ff - VEC_STEP;
						mem_ff.wdata <= save_pc_ff;
						state_ff <= PUSH_PC;
					end
				end
				PUSH_PC: begin
					if (mem_ack) begin
						mem_ff.we <= 1'b0;
						mem_ff.addr <= handler_addr;
						state_ff <= FETCH_HANDLER;
					end
				end
				FETCH_HANDLER: begin
					if (mem_ack) begin
						pc_ff <= mem_rdata;
						mem_ff.req <= 1'b0;
						pc_load_ff <= 1'b1;
						sp_load_ff <= 1'b1;
						core_hold_ff <= 1'b0;
						state_ff <= RUN;
					end
				end
				default: state_ff <= RUN;
				endcase
			end
		end
	end

	// Output flops
	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign cpu_init = cpu_init_ff;
	assign periph_init = periph_init_ff;
	assign port_init = port_init_ff;
	assign core_hold = core_hold_ff;
	assign mem_cmd = mem_ff;
	assign pc_out = pc_ff;
	assign sp_out = sp_ff;
	assign status_word_out = sr_ff;
	assign pc_load = pc_load_ff;
	assign sp_load = sp_load_ff;
	assign sr_load = sr_load_ff;
	assign addr_error = addr_error_ff;

	// Checks
	property p_pin_first;
		@(posedge clk) disable iff (!rst_n)
		por_pin |=> cpu_init && periph_init && port_init && state_ff == RST_HOLD;
	endproperty
	a_pin_first: assert property (p_pin_first) else $error("pin reset not taken");
	property p_wdt_ports;
		@(posedge clk) disable iff (!rst_n)
		!por_pin && wdt_rst |=> periph_init && !port_init && watchdog_overflow_flag_ff;
	endproperty
	a_wdt_ports: assert property (p_wdt_ports) else $error("watchdog reset wrong");
	property p_simul;
		@(posedge clk) disable iff (!rst_n)
		por_pin && watchdog_overflow |=> !watchdog_overflow_flag_ff && cause_ff == C_PIN;
	endproperty
	a_simul: assert property (p_simul) else $error("pin reset lost priority");
	property p_man_stall;
		@(posedge clk) disable iff (!rst_n)
		!por_pin && !wdt_rst && man_req && man_stall && !cpu_init |=> !cpu_init;
	endproperty
	a_man_stall: assert property (p_man_stall) else $error("bus cycle aborted");
	sequence s_leave_hold;
		state_ff == RST_HOLD ##1 state_ff == FETCH_PC;
	endsequence
	property p_vectors;
		@(posedge clk) disable iff (!rst_n)
		s_leave_hold |-> mem_cmd.req && !mem_cmd.we && vbase_ff == VBASE_RST &&
			mem_cmd.addr == (cause_ff == C_MAN ? VEC_MAN_PC : VEC_POR_PC);
	endproperty
	a_vectors: assert property (p_vectors) else $error("bad reset vector");
	property p_odd_fetch;
		@(posedge clk) disable iff (!rst_n)
		acc.valid && acc.fetch && acc.addr[0] |=> addr_error;
	endproperty
	a_odd_fetch: assert property (p_odd_fetch) else $error("odd fetch missed");
	property p_long_align;
		@(posedge clk) disable iff (!rst_n)
		acc.valid && !acc.fetch && acc.size == SZ_LONG && acc.addr[1:0] == 2'b10 |=> addr_error;
	endproperty
	a_long_align: assert property (p_long_align) else $error("misaligned long missed");
	property p_wait_instr;
		@(posedge clk) disable iff (!rst_n)
		state_ff == RUN && !instr_done |=> state_ff != PUSH_SR;
	endproperty
	a_wait_instr: assert property (p_wait_instr) else $error("error taken early");
	property p_handler;
		@(posedge clk) disable iff (!rst_n)
		state_ff == PUSH_PC && mem_ack && !por_pin && !wdt_rst && !man_req |=>
			mem_cmd.addr == handler_addr && state_ff == FETCH_HANDLER;
	endproperty
	a_handler: assert property (p_handler) else $error("bad handler address");
	property p_mask_kept;
		@(posedge clk) disable iff (!rst_n)
		state_ff == FETCH_HANDLER |=> !sr_load;
	endproperty
	a_mask_kept: assert property (p_mask_kept) else $error("mask touched");
endmodule

// file: rae_mem_model.sv
`timescale 1ns/10ps
module rae_mem_model import rae_pkg::*; #(
	parameter logic [31:0] KEY = 32'h1357_9bdf
) (
	input wire logic clk,
	input wire mem_cmd_t mem_cmd,
	output logic [31:0] mem_rdata,
	output logic mem_ack
);
	logic [1:0] wait_ff = 2'h0;
	logic slow_ff = 1'b0;
	initial mem_ack = 1'b0;
	initial mem_rdata = 32'h0;
	// Answers alternately at once and after three idle cycles
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata; // Data line not held outside the ack
		if (mem_cmd.req && !mem_ack) begin
			if (wait_ff == (slow_ff ? 2'h3 : 2'h0)) begin
				mem_ack <= 1'b1;
				mem_rdata <= mem_cmd.addr ^ KEY;
				wait_ff <= 2'h0;
				slow_ff <= !slow_ff;
			end else begin
				wait_ff <= wait_ff + 2'h1;
			end
		end
	end
endmodule

// file: rae_unit_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
	$display("Error at %0t: got %h want %h", $time, a, b); end end
module rae_unit_tb import rae_pkg::*;;
	localparam logic [31:0] KEY = 32'h1357_9bdf;
	typedef struct packed {access_t a; logic sc; logic err;} row_t;
	logic clk, resetn, power_on_reset_pin_n, manual_reset_pin_n, watchdog_overflow;
	logic bus_cycle_busy, instr_done, mem_ack, avs_read, avs_write, avs_waitrequest;
	logic cpu_init, periph_init, port_init, core_hold, pc_load, sp_load, sr_load, addr_error;
	access_t acc;
	mem_cmd_t mem_cmd;
	logic [3:0] avs_address;
	logic [31:0] cur_status_word, cur_stack_ptr, next_pc, mem_rdata, avs_writedata;
	logic [31:0] avs_readdata, pc_out, sp_out, status_word_out, q;
	logic [31:0] qa[$], qd[$];
	logic qw[$];
	int n_fail = 0, checked = 0, cyc = 0;
	// Offending and clean accesses with the expected error pulse
	row_t rows [11] = '{
		{1'b1, 1'b0, M_DMA, SZ_WORD, 32'h0000_1001, 1'b0, 1'b1},
		{1'b1, 1'b1, M_CPU, SZ_WORD, 32'h0000_1000, 1'b0, 1'b0},
		{1'b1, 1'b1, M_CPU, SZ_WORD, 32'h0000_1001, 1'b0, 1'b1},
		{1'b1, 1'b1, M_CPU, SZ_WORD, 32'hffff_9000, 1'b0, 1'b1},
		{1'b1, 1'b1, M_CPU, SZ_WORD, 32'h0040_0000, 1'b1, 1'b1},
		{1'b1, 1'b0, M_TRACE, SZ_LONG, 32'h0000_1002, 1'b0, 1'b1},
		{1'b1, 1'b0, M_XFER, SZ_LONG, 32'hffff_8000, 1'b0, 1'b1},
		{1'b1, 1'b0, M_CPU, SZ_LONG, 32'hffff_9000, 1'b0, 1'b0},
		{1'b1, 1'b0, M_DMA, SZ_BYTE, 32'hffff_8001, 1'b0, 1'b0},
		{1'b1, 1'b0, M_CPU, SZ_BYTE, 32'h0040_0000, 1'b1, 1'b1},
		{1'b1, 1'b1, M_CPU, SZ_WORD, 32'h0040_0000, 1'b0, 1'b0}
	};
	rae_unit u_rae_unit (.clk, .resetn, .power_on_reset_pin_n, .manual_reset_pin_n,
		.watchdog_overflow, .bus_cycle_busy, .instr_done, .acc, .cur_status_word,
		.cur_stack_ptr, .next_pc, .mem_rdata, .mem_ack, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .cpu_init,
		.periph_init, .port_init, .core_hold, .mem_cmd, .pc_out, .sp_out,
		.status_word_out, .pc_load, .sp_load, .sr_load, .addr_error);
	rae_mem_model #(.KEY(KEY)) u_rae_mem_model (.clk, .mem_cmd, .mem_rdata, .mem_ack);
	always #2.5 clk = ~clk;
	// Log every memory transfer at its ack
	always @(posedge clk) begin
		if (mem_cmd.req === 1'b1 && mem_ack === 1'b1) begin
			qa.push_back(mem_cmd.addr);
			qd.push_back(mem_cmd.wdata);
			qw.push_back(mem_cmd.we);
		end
	end
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_of_test;
		end
	end
	task end_of_test;
		$display("Checks %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// One register transfer, held until waitrequest is seen low
	task av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	task wait_load;
		int n;
		n = 0;
		while (pc_load !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		`CHK(n < 400, 1'b1)
	endtask
	// Vector pair, loads and base clear after a reset release
	task vec_chk(input logic [31:0] v, input string s);
		wait_load;
		`CHK(qa[0], v)
		`CHK(qa[1], v + VEC_STEP)
		`CHK(pc_out, v ^ KEY)
		`CHK(sp_out, (v + VEC_STEP) ^ KEY)
		`CHK({sp_load, sr_load}, 2'h3)
		`CHK(core_hold, 1'b0)
		`CHK(status_word_out[SR_IMASK+:4], IMASK_RST)
		av(1'b0, OFF_VBASE, 32'h0, q);
		`CHK(q, VBASE_RST)
		av(1'b1, OFF_VBASE, 32'h100, q);
		$display("test %s done", s);
	endtask
	// Empty the transfer log before a new sequence
	task clr_log;
		qa.delete();
		qw.delete();
		qd.delete();
	endtask
	task pulse_acc(input access_t a);
		acc <= a;
		@(posedge clk);
		acc.valid <= 1'b0;
		@(posedge clk);
	endtask
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		power_on_reset_pin_n = 1'b1;
		manual_reset_pin_n = 1'b1;
		{watchdog_overflow, bus_cycle_busy, instr_done, avs_read, avs_write} = 5'h0;
		acc = '0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		cur_status_word = 32'h0000_00a0;
		cur_stack_ptr = 32'h0000_2000;
		next_pc = 32'h0000_0456;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		vec_chk(VEC_POR_PC, "start");
		av(1'b0, 4'hc, 32'h0, q);
		`CHK(q, 32'h0)
		av(1'b0, OFF_VBASE, 32'h0, q);
		`CHK(q, 32'h100)
		for (int i = 0; i < 11; i++) begin
			av(1'b1, OFF_CTRL, 32'(rows[i].sc) << CTRL_SCHIP, q);
			pulse_acc(rows[i].a);
			`CHK(addr_error, rows[i].err)
		end
		av(1'b0, OFF_ERRADDR, 32'h0, q);
		`CHK(q, 32'h0000_1001)
		$display("test access table done");
		// Error entry waits for the bus cycle to end
		bus_cycle_busy <= 1'b1;
		instr_done <= 1'b1;
		clr_log;
		repeat (6) @(posedge clk);
		`CHK(mem_cmd.req, 1'b0)
		bus_cycle_busy <= 1'b0;
		wait_load;
		instr_done <= 1'b0;
		`CHK({qw[0], qa[0], qd[0]}, {1'b1, 32'h0000_1ffc, 32'h0000_00a0})
		`CHK({qw[1], qa[1], qd[1]}, {1'b1, 32'h0000_1ff8, 32'h0000_0456})
		`CHK({qw[2], qa[2]}, {1'b0, 32'h100 + 32'(VEC_AE_DMA) * 4})
		`CHK(pc_out, (32'h100 + 32'(VEC_AE_DMA) * 4) ^ KEY)
		`CHK({sp_out, sr_load}, {32'h0000_1ff8, 1'b0})
		$display("test address error done");
		// Manual reset held off by a running bus cycle
		bus_cycle_busy <= 1'b1;
		manual_reset_pin_n <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK(cpu_init, 1'b0)
		bus_cycle_busy <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK({cpu_init, periph_init, port_init}, 3'h4)
		`CHK(core_hold, 1'b1)
		repeat (25) @(posedge clk);
		clr_log;
		manual_reset_pin_n <= 1'b1;
		vec_chk(VEC_MAN_PC, "manual");
		// Watchdog overflow ignored, then honoured
		watchdog_overflow <= 1'b1;
		@(posedge clk);
		watchdog_overflow <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK(cpu_init, 1'b0)
		av(1'b1, OFF_CTRL, 32'h1 << CTRL_WDT_EN, q);
		clr_log;
		watchdog_overflow <= 1'b1;
		@(posedge clk);
		watchdog_overflow <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK({cpu_init, periph_init, port_init}, 3'h6)
		vec_chk(VEC_POR_PC, "watchdog");
		av(1'b0, OFF_CTRL, 32'h0, q);
		`CHK({q[CTRL_CAUSE+:2], q[CTRL_WATCHDOG_OVERFLOW_FLAG]}, {C_WDT, 1'b1})
		// Pin and watchdog together, with an error pending
		pulse_acc(rows[0].a);
		power_on_reset_pin_n <= 1'b0;
		instr_done <= 1'b1; // Pending error would be taken if kept
		watchdog_overflow <= 1'b1;
		@(posedge clk);
		watchdog_overflow <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK({cpu_init, periph_init, port_init}, 3'h7)
		repeat (25) @(posedge clk);
		clr_log;
		power_on_reset_pin_n <= 1'b1;
		vec_chk(VEC_POR_PC, "pin");
		`CHK(qw[0], 1'b0)
		`CHK(qa.size(), 2)
		`CHK(mem_cmd.req, 1'b0)
		av(1'b0, OFF_CTRL, 32'h0, q);
		`CHK({q[CTRL_CAUSE+:2], q[CTRL_WATCHDOG_OVERFLOW_FLAG]}, {C_PIN, 1'b0})
		// Core-side error goes through vector 9
		clr_log;
		pulse_acc(rows[2].a);
		wait_load;
		`CHK({qw[0], qa[0]}, {1'b1, 32'h0000_1ffc})
		`CHK({qw[1], qd[1]}, {1'b1, 32'h0000_0456})
		`CHK({qw[2], qa[2]}, {1'b0, 32'h100 + 32'(VEC_AE_CORE) * 4})
		`CHK(pc_out, (32'h100 + 32'(VEC_AE_CORE) * 4) ^ KEY)
		$display("test core error done");
		end_of_test;
	end
endmodule
